// *** rtl/bct_timer.sv ***
// eight-channel buffered capture/compare timer with pulse accumulators and an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns

// How it works
// - eight channels, direction bit picks capture/compare
// - unbuffered capture obeys the no-overwrite bit
// - read empties capture or holding, transfer empties capture
// - latch mode copies capture on three events
// - latch mode, overwrite allowed, always replaces
// - no-overwrite blocks writes into full registers
// - queue mode shifts capture into holding first
// - queue holding read moves and clears accumulator
// - four 8-bit accumulators, pairable to 16-bit
// - saturate bit stops unpaired accumulators at FF
// - latch events copy and clear accumulators
// - modulus down-counter latches periodically or once
// - enabled compare forces pin direction itself
// - port data written while pin is peripheral
// - force bits fire action, read as zero
// - channel-7 mask makes compare pin output
// - channel-7 compare loads masked pins from data
// - channel-7 mask blocks own output action
// - channel-7 wins same-cycle compare on pin
// - sixteen-bit free up counter, always readable
// - counter writable only in special mode
module bct_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bct_pkg::bct_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire bct_pkg::bct_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire bct_pkg::bct_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output bct_pkg::bct_data_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic special_mode_indicator_n,
  input wire logic [7:0] timer_port_in,
  output logic [7:0] timer_port_out,
  output logic [7:0] timer_port_oe
);
  import bct_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_idx(input bct_addr_t a);
    reg_idx = a[9:2];
  endfunction

  function automatic logic is_mapped(input bct_addr_t a);
    logic [7:0] i;
    i = reg_idx(a);
    is_mapped = (a[11:10] == 2'h0) && ((i >= IDX_DIR && i <= IDX_CNT) || (i >= IDX_TC0 && i <= IDX_PHOLD)
                || (i >= IDX_NOVW && i <= IDX_PORT));
  endfunction

  function automatic bct_data_t reg_read(input bct_state_s s, input logic [7:0] i);
    reg_read = '0;
    unique case (i)
      IDX_DIR: reg_read[7:0] = s.dir;
      IDX_C7M: reg_read[7:0] = s.c7m;
      IDX_C7D: reg_read[7:0] = s.c7d;
      IDX_CNT: reg_read[15:0] = s.cnt;
      IDX_PACC: reg_read = s.pa;
      IDX_PHOLD: reg_read = s.pa_hold;
      IDX_NOVW: reg_read[7:0] = s.novw;
      IDX_SYS: reg_read[2:0] = s.sys;
      IDX_MCTL: reg_read[1:0] = s.mctl;
      IDX_MCNT: reg_read[15:0] = s.mod_cnt;
      IDX_OUTCTL: reg_read[15:0] = s.outctl;
      IDX_EDGE: reg_read[15:0] = s.edge_ctl;
      IDX_DDR: reg_read[7:0] = s.ddr;
      IDX_PORT: reg_read[7:0] = s.port;
      default: begin
        if (i >= IDX_TC0 && i < IDX_HOLD0) begin
          reg_read[15:0] = s.tc[i[2:0]];
        end else if (i >= IDX_HOLD0 && i < IDX_PACC) begin
          reg_read[15:0] = s.hold[i[1:0]];
        end
      end
    endcase // force register falls to zero here
  endfunction

  function automatic bct_data_t merge(input bct_data_t o, input bct_data_t n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] pin_prev_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
      pin_prev_reg <= 8'h00;
    end else begin
      pin_meta_reg <= timer_port_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  bct_bus_s bus_reg;
  bct_bus_s bus_next;
  logic ar_take;
  logic do_wr;
  logic [7:0] rd_idx;
  logic [7:0] w_idx;

  bct_state_s st_reg;
  bct_state_s st_next;

  assign ar_take = s_axi_arvalid && bus_reg.arready;
  assign rd_idx = reg_idx(s_axi_araddr);
  assign w_idx = reg_idx(bus_reg.waddr);
  // address and data may arrive in either order; the write lands one cycle after both are held
  assign do_wr = bus_reg.aw_have && bus_reg.w_have && !bus_reg.bvalid && is_mapped(bus_reg.waddr);

  always_comb begin
    bus_next = bus_reg;
    if (s_axi_awvalid && bus_reg.awready) begin
      bus_next.aw_have = 1'b1;
      bus_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && bus_reg.wready) begin
      bus_next.w_have = 1'b1;
      bus_next.wdata = s_axi_wdata;
      bus_next.wstrb = s_axi_wstrb;
    end
    if (bus_reg.bvalid && s_axi_bready) begin
      bus_next.bvalid = 1'b0;
    end
    if (bus_reg.aw_have && bus_reg.w_have && !bus_reg.bvalid) begin
      bus_next.aw_have = 1'b0;
      bus_next.w_have = 1'b0;
      bus_next.bvalid = 1'b1;
      bus_next.bresp = is_mapped(bus_reg.waddr) ? AXI_OKAY : AXI_SLVERR;
    end
    bus_next.awready = !bus_next.aw_have && !bus_next.bvalid;
    bus_next.wready = !bus_next.w_have && !bus_next.bvalid;
    if (bus_reg.rvalid && s_axi_rready) begin
      bus_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      bus_next.rvalid = 1'b1;
      bus_next.rdata = is_mapped(s_axi_araddr) ? reg_read(st_reg, rd_idx) : '0;
      bus_next.rresp = is_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
    end
    bus_next.arready = !bus_next.rvalid;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_reg <= BUS_RST;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // ----------------------------------------------------------------
  // timer core
  // ----------------------------------------------------------------
  logic [7:0] edge_ev;
  logic [7:0] cap_ev;
  logic [7:0] act;
  logic [7:0] oc_drive;
  logic zero_ev;
  logic latch_ev;
  logic latch_or_queue_select;
  bct_data_t wd;

  always_comb begin
    st_next = st_reg;
    wd = merge(reg_read(st_reg, w_idx), bus_reg.wdata, bus_reg.wstrb);
    latch_or_queue_select = st_reg.sys[SYS_LATCH_OR_QUEUE_SELECT];
    for (int i = 0; i < NCH; i++) begin
      edge_ev[i] = (st_reg.edge_ctl[2*i] && pin_sync_reg[i] && !pin_prev_reg[i])
                || (st_reg.edge_ctl[2*i+1] && !pin_sync_reg[i] && pin_prev_reg[i]);
    end
    cap_ev = edge_ev & ~st_reg.dir;
    // modulus reaching zero; a once-only setting stops at zero and fires a single time
    zero_ev = st_reg.mctl[MCTL_EN] && (st_reg.mod_cnt == MOD_ONE);
    latch_ev = zero_ev || (do_wr && w_idx == IDX_MCNT && wd[15:0] == MOD_ZERO)
            || (do_wr && w_idx == IDX_MCTL && wd[MCTL_FLAT]);
    st_next.cnt = st_reg.cnt + 16'h0001;
    if (st_reg.mctl[MCTL_EN] && st_reg.mod_cnt != MOD_ZERO) begin
      st_next.mod_cnt = (zero_ev && st_reg.mctl[MCTL_PERIODIC]) ? st_reg.mod_load : st_reg.mod_cnt - MOD_ONE;
    end
    // compare hits on the counter value before it advances
    for (int i = 0; i < NCH; i++) begin
      act[i] = st_reg.dir[i] && (st_reg.tc[i] == st_reg.cnt);
    end
    // reads empty registers first so that a same-cycle capture still wins
    if (ar_take) begin
      for (int i = 0; i < NCH; i++) begin
        if (rd_idx == IDX_TC0 + 8'(i) && !st_reg.dir[i]) begin
          st_next.cap_empty[i] = 1'b1;
        end
      end
      for (int i = 0; i < NBUF; i++) begin
        if (rd_idx == IDX_HOLD0 + 8'(i)) begin
          st_next.hold_empty[i] = 1'b1;
          if (!latch_or_queue_select) begin
            st_next.pa_hold[i] = st_reg.pa[i];
            st_next.pa[i] = 8'h00;
          end
        end
      end
    end
    if (do_wr) begin
      unique case (w_idx)
        IDX_DIR: st_next.dir = wd[7:0];
        IDX_FORCE: act = act | (wd[7:0] & st_reg.dir); // no flag exists to set
        IDX_C7M: st_next.c7m = wd[7:0];
        IDX_C7D: st_next.c7d = wd[7:0];
        IDX_CNT: begin
          if (!special_mode_indicator_n) begin
            st_next.cnt = wd[15:0];
          end
        end
        IDX_NOVW: st_next.novw = wd[7:0];
        IDX_SYS: st_next.sys = wd[2:0];
        IDX_MCTL: st_next.mctl = wd[1:0];
        IDX_MCNT: begin
          st_next.mod_load = wd[15:0];
          st_next.mod_cnt = wd[15:0];
        end
        IDX_OUTCTL: st_next.outctl = wd[15:0];
        IDX_EDGE: st_next.edge_ctl = wd[15:0];
        IDX_DDR: st_next.ddr = wd[7:0];
        IDX_PORT: st_next.port = wd[7:0]; // latched even while the pin is peripheral
        default: begin
          if (w_idx >= IDX_TC0 && w_idx < IDX_HOLD0) begin
            st_next.tc[w_idx[2:0]] = wd[15:0];
          end
        end
      endcase
    end
    // latch events before captures so a same-cycle capture lands behind the copy
    if (latch_ev && latch_or_queue_select) begin
      for (int i = 0; i < NBUF; i++) begin
        if (!st_reg.novw[i] || st_next.hold_empty[i]) begin
          st_next.hold[i] = st_reg.tc[i];
          st_next.hold_empty[i] = 1'b0;
          st_next.cap_empty[i] = 1'b1;
        end
        st_next.pa_hold[i] = st_reg.pa[i];
        st_next.pa[i] = 8'h00;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (cap_ev[i]) begin
        if (i < NBUF && !latch_or_queue_select) begin
          // queue: shift into holding when allowed, then take the new value
          if (!st_next.cap_empty[i] && (!st_reg.novw[i] || st_next.hold_empty[i])) begin
            st_next.hold[i] = st_next.tc[i];
            st_next.hold_empty[i] = 1'b0;
            st_next.cap_empty[i] = 1'b1;
          end
        end
        if (!st_reg.novw[i] || st_next.cap_empty[i]) begin
          st_next.tc[i] = st_reg.cnt;
          st_next.cap_empty[i] = 1'b0;
        end
      end
    end
    // accumulators count after any clear, so an edge in the clearing cycle is kept
    for (int k = 0; k < NBUF; k += 2) begin
      if (st_reg.sys[SYS_PAIR16]) begin
        if (edge_ev[k]) begin
          {st_next.pa[k+1], st_next.pa[k]} = {st_next.pa[k+1], st_next.pa[k]} + 16'h0001;
        end
      end else begin
        for (int j = k; j < k + 2; j++) begin
          if (edge_ev[j] && !(st_reg.sys[SYS_SAT] && st_next.pa[j] == PA_MAX)) begin
            st_next.pa[j] = st_next.pa[j] + 8'h01;
          end
        end
      end
    end
    // output actions; channel 7 data overrides masked pins
    for (int i = 0; i < NCH; i++) begin
      if (act[7] && st_reg.c7m[i]) begin
        st_next.oc_lvl[i] = st_reg.c7d[i];
      end else if (act[i] && !st_reg.c7m[i]) begin
        unique case (st_reg.outctl[2*i +: 2])
          2'h1: st_next.oc_lvl[i] = !st_reg.oc_lvl[i];
          2'h2: st_next.oc_lvl[i] = 1'b0;
          2'h3: st_next.oc_lvl[i] = 1'b1;
          2'h0: st_next.oc_lvl[i] = st_reg.oc_lvl[i];
        endcase
      end
      oc_drive[i] = st_next.dir[i] && (st_next.c7m[i] || st_next.outctl[2*i +: 2] != 2'h0);
    end
    st_next.pin_oe = oc_drive | st_next.ddr;
    st_next.pin_out = (oc_drive & st_next.oc_lvl) | (~oc_drive & st_next.port);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = bus_reg.awready;
  assign s_axi_wready = bus_reg.wready;
  assign s_axi_bvalid = bus_reg.bvalid;
  assign s_axi_bresp = bus_reg.bresp;
  assign s_axi_arready = bus_reg.arready;
  assign s_axi_rvalid = bus_reg.rvalid;
  assign s_axi_rdata = bus_reg.rdata;
  assign s_axi_rresp = bus_reg.rresp;
  assign timer_port_out = st_reg.pin_out;
  assign timer_port_oe = st_reg.pin_oe;

endmodule // bct_timer

// *** rtl/bct_pkg.sv ***
// package: register map, bit positions, reset values and state types of the capture/compare timer
package bct_pkg;

  typedef logic [11:0] bct_addr_t;
  typedef logic [31:0] bct_data_t;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DIR = 8'h80;
  localparam logic [7:0] IDX_FORCE = 8'h81;
  localparam logic [7:0] IDX_C7M = 8'h82;
  localparam logic [7:0] IDX_C7D = 8'h83;
  localparam logic [7:0] IDX_CNT = 8'h84;
  localparam logic [7:0] IDX_TC0 = 8'h90;
  localparam logic [7:0] IDX_HOLD0 = 8'h98;
  localparam logic [7:0] IDX_PACC = 8'h9C;
  localparam logic [7:0] IDX_PHOLD = 8'h9D;
  localparam logic [7:0] IDX_NOVW = 8'hA0;
  localparam logic [7:0] IDX_SYS = 8'hA1;
  localparam logic [7:0] IDX_MCTL = 8'hA2;
  localparam logic [7:0] IDX_MCNT = 8'hA3;
  localparam logic [7:0] IDX_OUTCTL = 8'hA4;
  localparam logic [7:0] IDX_EDGE = 8'hA5;
  localparam logic [7:0] IDX_DDR = 8'hA6;
  localparam logic [7:0] IDX_PORT = 8'hA7;

  // ----------------------------------------------------------------
  // field positions and counts
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int NBUF = 4;
  localparam int SYS_LATCH_OR_QUEUE_SELECT = 0;
  localparam int SYS_SAT = 1;
  localparam int SYS_PAIR16 = 2;
  localparam int MCTL_EN = 0;
  localparam int MCTL_PERIODIC = 1;
  localparam int MCTL_FLAT = 2;
  localparam logic [7:0] PA_MAX = 8'hFF;
  localparam logic [15:0] MOD_ZERO = 16'h0000;
  localparam logic [15:0] MOD_ONE = 16'h0001;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // state carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] c7m;
    logic [7:0] c7d;
    logic [7:0] novw;
    logic [7:0] ddr;
    logic [7:0] port;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] oc_lvl;
    logic [7:0] cap_empty;
    logic [3:0] hold_empty;
    logic [2:0] sys;
    logic [1:0] mctl;
    logic [15:0] cnt;
    logic [15:0] mod_load;
    logic [15:0] mod_cnt;
    logic [15:0] outctl;
    logic [15:0] edge_ctl;
    logic [7:0][15:0] tc;
    logic [3:0][15:0] hold;
    logic [3:0][7:0] pa;
    logic [3:0][7:0] pa_hold;
  } bct_state_s;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    bct_addr_t waddr;
    bct_data_t wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    bct_data_t rdata;
    logic [1:0] rresp;
  } bct_bus_s;

  localparam bct_state_s ST_RST = '{cap_empty: 8'hFF, hold_empty: 4'hF, default: '0};
  localparam bct_bus_s BUS_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// *** verification/bct_timer_props.sv ***
// checker: bus handshake, readback and pin-enable properties of the timer
`timescale 1ns/1ns
module bct_timer_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bct_pkg::bct_addr_t s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire bct_pkg::bct_data_t s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] timer_port_oe
);
  import bct_pkg::*;
  logic ar_hs;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late or early");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_NEXT: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not next cycle");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_FORCE_ZERO: assert property (
    ar_hs && s_axi_araddr == {2'h0, IDX_FORCE, 2'h0} |=> s_axi_rdata == 32'h0)
    else $error("force register read not zero");
  AST_UNMAPPED: assert property (ar_hs && s_axi_araddr[9:2] < IDX_DIR
    |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  // oe follows register state only, so it moves only around a write response
  AST_OE_CAUSE: assert property (
    $changed(timer_port_oe) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("oe moved alone");
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
  COV_OE: cover property ($rose(timer_port_oe[0]));
endmodule // bct_timer_props
bind bct_timer bct_timer_props u_props (.*);

// *** verification/bct_pins.sv ***
// partner: external drivers on the timer port pins
`timescale 1ns/1ns
module bct_pins (
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  output logic [7:0] pin_lvl
);
  // where the block drives, the outside source is off the wire
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_lvl[i] = port_oe[i] ? port_out[i] : ext_drv[i];
    end
  end
endmodule // bct_pins

// *** verification/bct_timer_tb_top.sv ***
// testbench: register-level tests of the capture/compare timer
`timescale 1ns/1ns
module bct_timer_tb_top;
  import bct_pkg::*;
  logic sys_clk, rst, special_mode_indicator_n;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  bct_addr_t s_axi_awaddr, s_axi_araddr;
  bct_data_t s_axi_wdata, s_axi_rdata, a, c, h;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] ext, timer_port_in, timer_port_out, timer_port_oe;
  int miscompares, n_checks;
  bct_timer dut (.*);
  bct_pins u_pins (.ext_drv(ext), .port_out(timer_port_out), .port_oe(timer_port_oe), .pin_lvl(timer_port_in));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge sys_clk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output bct_data_t d);
    @(posedge sys_clk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    rd(i, c);
    chk(c & m, e);
  endtask
  task automatic pulse(input int ch, input int n, input int len);
    repeat (n) begin
      ext[ch] <= 1'b1;
      repeat (len) @(posedge sys_clk);
      ext[ch] <= 1'b0;
      repeat (len) @(posedge sys_clk);
    end
  endtask
  // pin outputs change on the same edge that the write lands
  task automatic pc(input int i, input logic [1:0] e);
    repeat (3) @(posedge sys_clk);
    chk(32'({timer_port_oe[i], timer_port_out[i]}), 32'(e));
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {rst, special_mode_indicator_n} = 2'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rc(IDX_DIR, 32'h0);
    rc(8'h10, 32'h0);
    chk(32'(resp), 32'(AXI_SLVERR));
    wr(8'h10, 32'h1);
    chk(32'(resp), 32'(AXI_SLVERR));
    rd(IDX_CNT, a);
    rd(IDX_CNT, c);
    chk(32'(c[15:0] > a[15:0]), 32'h1);
    wr(IDX_CNT, 32'h8000);
    rd(IDX_CNT, c);
    chk(32'(c[15:0] < 16'h8000), 32'h1);
    special_mode_indicator_n <= 1'b0;
    wr(IDX_CNT, 32'h8000);
    rd(IDX_CNT, c);
    chk(32'(c[15:0] >= 16'h8000 && c[15:0] < 16'h8100), 32'h1);
    $display("test counter done");
    wr(IDX_EDGE, 32'h0115);
    // first capture lands within a few cycles, the second twenty later
    for (int k = 0; k < 2; k++) begin
      wr(IDX_NOVW, 32'(k == 0 ? 8'h10 : 8'h00));
      rd(IDX_CNT, a);
      pulse(4, 2, 10);
      rd(IDX_TC0 + 8'h4, c);
      chk(32'(c[15:0] - a[15:0] > 16'd15), 32'(k));
    end
    pulse(0, 2, 10);
    rc(IDX_PACC, 32'h2, 32'hFF);
    rd(IDX_HOLD0, h);
    rd(IDX_TC0, c);
    chk(c - h, 32'd20);
    rc(IDX_PHOLD, 32'h2, 32'hFF);
    rc(IDX_PACC, 32'h0, 32'hFF);
    $display("test queue done");
    wr(IDX_SYS, 32'h1);
    pulse(1, 3, 10);
    wr(IDX_MCTL, 32'h4);
    rc(IDX_PHOLD, 32'h0300, 32'hFF00);
    rc(IDX_PACC, 32'h0, 32'hFF00);
    rd(IDX_TC0 + 8'h1, h);
    rc(IDX_HOLD0 + 8'h1, h);
    pulse(1, 1, 10);
    wr(IDX_MCNT, 32'h0);
    rc(IDX_PHOLD, 32'h0100, 32'hFF00);
    wr(IDX_MCTL, 32'h1);
    pulse(1, 2, 10);
    wr(IDX_MCNT, 32'h5);
    repeat (12) @(posedge sys_clk);
    rc(IDX_PHOLD, 32'h0200, 32'hFF00);
    wr(IDX_SYS, 32'h3);
    pulse(2, 260, 4);
    rc(IDX_PACC, 32'h00FF0000, 32'h00FF0000);
    $display("test latch done");
    wr(IDX_DIR, 32'h83);
    rc(IDX_DIR, 32'h83);
    chk(32'(resp), 32'(AXI_OKAY));
    wr(IDX_OUTCTL, 32'h3);
    wr(IDX_FORCE, 32'h1);
    pc(0, 2'h3);
    rc(IDX_FORCE, 32'h0);
    wr(IDX_C7D, 32'h0);
    wr(IDX_C7M, 32'h3);
    pc(1, 2'h2);
    rc(IDX_DDR, 32'h0);
    wr(IDX_FORCE, 32'h80);
    pc(0, 2'h2);
    wr(IDX_FORCE, 32'h1);
    pc(0, 2'h2);
    wr(IDX_OUTCTL, 32'h2);
    wr(IDX_C7D, 32'h1);
    wr(IDX_FORCE, 32'h81);
    pc(0, 2'h3);
    // a one differs from the reset value, so the latched write shows later
    wr(IDX_PORT, 32'h1);
    pc(0, 2'h3);
    wr(IDX_OUTCTL, 32'h0);
    wr(IDX_C7M, 32'h0);
    wr(IDX_DIR, 32'h0);
    wr(IDX_DDR, 32'h1);
    pc(0, 2'h3);
    $display("test compare done");
    complete_run();
  end
endmodule // bct_timer_tb_top
